// ===== rtl/ook_pkg.sv
// Shared constants, types and helpers for the on-off keying and test sequence link
package ook_pkg;

  // Core clock and serial clock timing
  localparam int CORE_MHZ = 40;
  localparam int SCLK_HALF_NS = 500;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CORE_MHZ + 999) / 1000;
  localparam logic [5:0] HALF_CNT_MAX = 6'(SCLK_HALF_CYC - 1);
  // Majority threshold over one bit period of samples
  localparam logic [5:0] FILT_THRESH = 6'(SCLK_HALF_CYC);

  // Modulation selection
  localparam logic [3:0] OOK_MANTISSA = 4'h0;
  localparam logic [3:0] FSK_MANTISSA_MIN = 4'h1;

  // Power-down mode field codes
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_LOCK_WAIT = 2'h1;

  // Gain averaging and channel bandwidth factors
  localparam logic [1:0] GAIN_AVG_OOK = 2'h3;
  localparam logic [1:0] GAIN_AVG_FSK = 2'h1;
  localparam logic [2:0] BW_NONE = 3'h0;
  localparam logic [2:0] BW_X2 = 3'h2;
  localparam logic [2:0] BW_X4 = 3'h4;

  // Symbol rate limits, in units of 100 Baud
  localparam logic [11:0] RATE_MIN_OOK = 12'h018;
  localparam logic [11:0] RATE_X4_MAX = 12'h060;

  // Test sequence generator
  localparam int PN_LEN = 9;
  localparam int PN_TAP = 5;
  localparam logic [8:0] PN_SEED = 9'h1ff;
  localparam logic [3:0] BER_DISCARD = 4'h9;
  // Cycles after arming in which the data pin still settles from its release
  localparam logic [2:0] ARM_SETTLE = 3'h4;

  // Host framing
  localparam logic [2:0] DUMMY_CHIPS_FSK = 3'h2;
  localparam logic [2:0] DUMMY_CHIPS_OOK = 3'h4;
  localparam logic [2:0] LOCK_SETTLE = 3'h4;

  typedef enum logic [1:0] {
    BER_OFF = 2'h0,
    BER_ZEROS = 2'h1,
    BER_ONES = 2'h2
  } ber_mode_type;

  // Degree-nine and degree-five taps feed the new low bit
  function automatic logic [8:0] pn9_next(input logic [8:0] s);
    pn9_next = {s[7:0], s[PN_LEN-1] ^ s[PN_TAP-1]};
  endfunction : pn9_next

endpackage : ook_pkg

// ===== rtl/ook_pn9_device.sv
// Device end: serial clock source, on-off keying, test sequence scrambler, clock pin interrupt
module ook_pn9_device
  import ook_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Link to host
  serial_link_if.device link,
  // Radio side
  input wire logic synth_locked_in,
  input wire logic [7:0] rssi_level_in,
  input wire logic [7:0] cs_threshold_in,
  input wire logic fsk_rx_bit_in,
  output logic carrier_on_out,
  output logic fsk_shift_out,
  output logic carrier_sense_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the lock indication and the data pin

  logic lock_s1_ff;
  logic lock_s2_ff;
  logic data_s1_ff;
  logic data_s2_ff;
  logic data_prev_ff;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
      data_s1_ff <= 1'b1;
      data_s2_ff <= 1'b1;
      data_prev_ff <= 1'b1;
    end else if (ce_in) begin
      lock_s1_ff <= synth_locked_in;
      lock_s2_ff <= lock_s1_ff;
      data_s1_ff <= link.serial_data_pin;
      data_s2_ff <= data_s1_ff;
      data_prev_ff <= data_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock divider

  logic [5:0] half_cnt_ff;
  logic sclk_ff;
  logic half_end;
  logic rise_tick;
  logic fall_tick;

  assign half_end = (half_cnt_ff == HALF_CNT_MAX);
  assign rise_tick = half_end && !sclk_ff;
  assign fall_tick = half_end && sclk_ff;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      half_cnt_ff <= 6'h00;
      sclk_ff <= 1'b0;
    end else if (ce_in) begin
      if (half_end) begin
        half_cnt_ff <= 6'h00;
        sclk_ff <= !sclk_ff;
      end else begin
        half_cnt_ff <= half_cnt_ff + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and carrier sense

  logic ook_mode;
  logic level_above;
  logic cs_ff;

  assign ook_mode = (link.frequency_shift_config_mantissa == OOK_MANTISSA);
  assign level_above = (rssi_level_in >= cs_threshold_in);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cs_ff <= 1'b0;
    end else if (ce_in) begin
      cs_ff <= level_above;
    end
  end

  assign carrier_sense_out = cs_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence generator

  logic en_d_ff;
  logic armed_ff;
  logic run_ff;
  logic [2:0] arm_wait_ff;
  logic [8:0] pn_ff;
  logic pn_bit;

  // A stopped generator contributes nothing to the data
  assign pn_bit = run_ff && pn_ff[PN_LEN-1];

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_d_ff <= 1'b0;
      arm_wait_ff <= 3'h0;
      armed_ff <= 1'b0;
      run_ff <= 1'b0;
      pn_ff <= PN_SEED;
    end else if (ce_in) begin
      en_d_ff <= link.test_sequence_enable;
      if (!link.test_sequence_enable) begin
        armed_ff <= 1'b0;
        run_ff <= 1'b0;
      end else if (!en_d_ff) begin
        pn_ff <= PN_SEED;
        armed_ff <= 1'b1;
        run_ff <= 1'b0;
        arm_wait_ff <= ARM_SETTLE;
      end else if (armed_ff && (arm_wait_ff != 3'h0)) begin
        // Our own release of the pin is not a start edge
        arm_wait_ff <= arm_wait_ff - 3'h1;
      end else if (armed_ff && (data_s2_ff != data_prev_ff)) begin
        armed_ff <= 1'b0;
        run_ff <= 1'b1;
      end else if (run_ff && fall_tick) begin
        pn_ff <= pn9_next(pn_ff);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive: decimating majority filter and bit decision

  logic filt_in;
  logic [5:0] filt_cnt_ff;
  logic rx_bit_ff;
  logic rx_decision;

  // On-off keying slices the level; frequency shift uses the discriminator
  assign filt_in = ook_mode ? level_above : fsk_rx_bit_in;
  assign rx_decision = (filt_cnt_ff > FILT_THRESH);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      filt_cnt_ff <= 6'h00;
      rx_bit_ff <= 1'b1;
    end else if (ce_in) begin
      if (fall_tick) begin
        filt_cnt_ff <= {5'h00, filt_in};
        rx_bit_ff <= rx_decision ^ pn_bit;
      end else begin
        filt_cnt_ff <= filt_cnt_ff + {5'h00, filt_in};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit: modulator driven from the sampled host bit

  logic mod_bit;
  logic carrier_on_ff;
  logic fsk_shift_ff;

  assign mod_bit = data_s2_ff ^ pn_bit;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      carrier_on_ff <= 1'b0;
      fsk_shift_ff <= 1'b0;
    end else if (ce_in) begin
      if (!link.tx_mode) begin
        carrier_on_ff <= 1'b0;
        fsk_shift_ff <= 1'b0;
      end else if (rise_tick) begin
        carrier_on_ff <= ook_mode ? mod_bit : 1'b1;
        fsk_shift_ff <= ook_mode ? 1'b0 : mod_bit;
      end
    end
  end

  assign carrier_on_out = carrier_on_ff;
  assign fsk_shift_out = fsk_shift_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock pin and data pin drive

  logic nxt_clk_pin;
  logic clk_pin_ff;
  logic nxt_dev_oe;
  logic dev_oe_ff;

  always_comb begin
    if ((link.powerdown_mode_field == PD_LOCK_WAIT) && link.clock_pin_lock_gate) begin
      nxt_clk_pin = !lock_s2_ff;
    end else if (link.clock_pin_sense_gate && !link.tx_mode) begin
      nxt_clk_pin = cs_ff ? sclk_ff : 1'b1;
    end else begin
      nxt_clk_pin = sclk_ff;
    end
  end

  // Released while armed so the host can make the starting transition
  assign nxt_dev_oe = !link.tx_mode && !armed_ff;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_pin_ff <= 1'b1;
      dev_oe_ff <= 1'b0;
    end else if (ce_in) begin
      clk_pin_ff <= nxt_clk_pin;
      dev_oe_ff <= nxt_dev_oe;
    end
  end

  assign link.serial_clock_pin = clk_pin_ff;
  assign link.data_dev_out = rx_bit_ff;
  assign link.data_dev_oe = dev_oe_ff;

endmodule : ook_pn9_device

// ===== rtl/ook_pn9_host.sv
// Host end: configuration, bit framing, lock wait and error counting
module ook_pn9_host
  import ook_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Link to device
  serial_link_if.host link,
  // Configuration requests
  input wire logic ook_req_in,
  input wire logic [3:0] fsk_mantissa_in,
  input wire logic [11:0] rate_in,
  input wire logic test_seq_in,
  input wire logic tx_mode_in,
  input wire logic sense_gate_req_in,
  input wire logic wait_lock_req_in,
  input wire ber_mode_type ber_mode_in,
  // Transmit stream
  input wire logic tx_valid_in,
  input wire logic tx_bit_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  // Receive stream and status
  output logic rx_valid_out,
  output logic rx_bit_out,
  output logic lock_irq_out,
  output logic cfg_error_out,
  output logic [15:0] ber_count_out
);

  typedef enum logic [1:0] {
    LK_IDLE = 2'b01,
    LK_WAIT = 2'b10
  } lock_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect

  logic clk_s1_ff;
  logic clk_s2_ff;
  logic clk_prev_ff;
  logic dat_s1_ff;
  logic dat_s2_ff;
  logic rise;
  logic fall;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_s1_ff <= 1'b1;
      clk_s2_ff <= 1'b1;
      clk_prev_ff <= 1'b1;
      dat_s1_ff <= 1'b1;
      dat_s2_ff <= 1'b1;
    end else if (ce_in) begin
      clk_s1_ff <= link.serial_clock_pin;
      clk_s2_ff <= clk_s1_ff;
      clk_prev_ff <= clk_s2_ff;
      dat_s1_ff <= link.serial_data_pin;
      dat_s2_ff <= dat_s1_ff;
    end
  end

  assign rise = clk_s2_ff && !clk_prev_ff;
  assign fall = !clk_s2_ff && clk_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration

  logic ook_ok;
  logic ook_ff;
  logic [3:0] mant_ff;
  logic tx_mode_ff;
  logic sense_ff;
  logic seq_ff;
  logic err_ff;

  assign ook_ok = ook_req_in && (rate_in >= RATE_MIN_OOK);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ook_ff <= 1'b0;
      mant_ff <= FSK_MANTISSA_MIN;
      tx_mode_ff <= 1'b0;
      sense_ff <= 1'b0;
      seq_ff <= 1'b0;
      err_ff <= 1'b0;
    end else if (ce_in) begin
      ook_ff <= ook_ok;
      // A zero frequency-shift request would silently select on-off keying
      if (ook_ok) begin
        mant_ff <= OOK_MANTISSA;
      end else begin
        mant_ff <= (fsk_mantissa_in == OOK_MANTISSA) ? FSK_MANTISSA_MIN : fsk_mantissa_in;
      end
      tx_mode_ff <= tx_mode_in;
      sense_ff <= sense_gate_req_in && !tx_mode_in;
      seq_ff <= test_seq_in;
      err_ff <= ook_req_in && !ook_ok;
    end
  end

  assign link.frequency_shift_config_mantissa = mant_ff;
  assign link.tx_mode = tx_mode_ff;
  assign link.clock_pin_sense_gate = sense_ff;
  assign link.test_sequence_enable = seq_ff;
  assign link.gain_average_setting = ook_ff ? GAIN_AVG_OOK : GAIN_AVG_FSK;
  assign link.channel_bw_factor = !ook_ff ? BW_NONE : ((rate_in <= RATE_X4_MAX) ? BW_X4 : BW_X2);
  assign link.afc_enable = !ook_ff;
  assign cfg_error_out = err_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Lock wait on the serial clock pin

  lock_state_type lk_state_ff;
  logic [2:0] settle_ff;
  logic [1:0] pd_ff;
  logic lock_gate_ff;
  logic irq_ff;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lk_state_ff <= LK_IDLE;
      settle_ff <= 3'h0;
      pd_ff <= PD_NORMAL;
      lock_gate_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce_in) begin
      irq_ff <= 1'b0;
      unique case (lk_state_ff)
        LK_IDLE: begin
          if (wait_lock_req_in) begin
            pd_ff <= PD_LOCK_WAIT;
            lock_gate_ff <= 1'b1;
            settle_ff <= LOCK_SETTLE;
            lk_state_ff <= LK_WAIT;
          end
        end
        LK_WAIT: begin
          // Stale clock lows still sit in the synchroniser
          if (settle_ff != 3'h0) begin
            settle_ff <= settle_ff - 3'h1;
          end else if (!clk_s2_ff) begin
            pd_ff <= PD_NORMAL;
            lock_gate_ff <= 1'b0;
            irq_ff <= 1'b1;
            lk_state_ff <= LK_IDLE;
          end
        end
      endcase
    end
  end

  assign link.powerdown_mode_field = pd_ff;
  assign link.clock_pin_lock_gate = lock_gate_ff;
  assign lock_irq_out = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit framing, Manchester chips, dummy tail, start kick

  logic half_ff;
  logic cur_ff;
  logic [2:0] dummy_ff;
  logic dout_ff;
  logic seq_d_ff;
  logic kick_pend_ff;
  logic kick_drv_ff;

  assign tx_ready_out = fall && tx_mode_ff && !kick_pend_ff && !half_ff && (dummy_ff == 3'h0);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      half_ff <= 1'b0;
      cur_ff <= 1'b0;
      dummy_ff <= 3'h0;
      dout_ff <= 1'b1;
      seq_d_ff <= 1'b0;
      kick_pend_ff <= 1'b0;
      kick_drv_ff <= 1'b0;
    end else if (ce_in) begin
      seq_d_ff <= seq_ff;
      if (seq_ff && !seq_d_ff) begin
        kick_pend_ff <= 1'b1;
      end else if (fall && kick_pend_ff) begin
        kick_pend_ff <= 1'b0;
      end
      if (fall) begin
        kick_drv_ff <= kick_pend_ff && !tx_mode_ff;
        if (kick_pend_ff) begin
          // Released pin idles high, so a low kick always makes an edge
          dout_ff <= tx_mode_ff ? !dat_s2_ff : 1'b0;
        end else if (half_ff) begin
          dout_ff <= !cur_ff;
          half_ff <= 1'b0;
        end else if (dummy_ff != 3'h0) begin
          dout_ff <= dummy_ff[0];
          dummy_ff <= dummy_ff - 3'h1;
        end else if (tx_ready_out && tx_valid_in) begin
          dout_ff <= tx_bit_in;
          cur_ff <= tx_bit_in;
          half_ff <= ook_ff;
          if (tx_last_in) begin
            dummy_ff <= ook_ff ? DUMMY_CHIPS_OOK : DUMMY_CHIPS_FSK;
          end
        end
      end
    end
  end

  assign link.data_host_out = dout_ff;
  assign link.data_host_oe = tx_mode_ff || kick_drv_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Receive sampling, Manchester decode, error counting

  logic phase_ff;
  logic rxv_ff;
  logic rxb_ff;
  logic [3:0] seen_ff;
  logic [15:0] ber_ff;
  logic take;

  assign take = rise && !tx_mode_ff && !kick_drv_ff && !(ook_ff && phase_ff);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_ff <= 1'b0;
      rxv_ff <= 1'b0;
      rxb_ff <= 1'b0;
    end else if (ce_in) begin
      rxv_ff <= take;
      if (rise && !tx_mode_ff) begin
        phase_ff <= ook_ff && !phase_ff;
      end
      if (take) begin
        rxb_ff <= dat_s2_ff;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seen_ff <= 4'h0;
      ber_ff <= 16'h0000;
    end else if (ce_in) begin
      if (ber_mode_in == BER_OFF) begin
        seen_ff <= 4'h0;
        ber_ff <= 16'h0000;
      end else if (rxv_ff) begin
        if (seen_ff != BER_DISCARD) begin
          seen_ff <= seen_ff + 4'h1;
        end else if (rxb_ff == (ber_mode_in == BER_ZEROS)) begin
          ber_ff <= ber_ff + 16'h0001;
        end
      end
    end
  end

  assign rx_valid_out = rxv_ff;
  assign rx_bit_out = rxb_ff;
  assign ber_count_out = ber_ff;

endmodule : ook_pn9_host

// ===== rtl/serial_link_if.sv
// Serial clock, serial data and configuration wires between device and host
interface serial_link_if;
  logic serial_clock_pin;
  logic data_dev_out;
  logic data_dev_oe;
  logic data_host_out;
  logic data_host_oe;
  logic serial_data_pin;
  logic [3:0] frequency_shift_config_mantissa;
  logic test_sequence_enable;
  logic [1:0] powerdown_mode_field;
  logic clock_pin_lock_gate;
  logic clock_pin_sense_gate;
  logic tx_mode;
  logic [1:0] gain_average_setting;
  logic [2:0] channel_bw_factor;
  logic afc_enable;

  // Device wins a clash; an undriven pin is pulled high
  assign serial_data_pin = data_dev_oe ? data_dev_out : (data_host_oe ? data_host_out : 1'b1);

  modport device (
    output serial_clock_pin, data_dev_out, data_dev_oe,
    input serial_data_pin, frequency_shift_config_mantissa, test_sequence_enable, powerdown_mode_field,
    input clock_pin_lock_gate, clock_pin_sense_gate, tx_mode, gain_average_setting,
    input channel_bw_factor, afc_enable
  );

  modport host (
    input serial_clock_pin, serial_data_pin,
    output data_host_out, data_host_oe, frequency_shift_config_mantissa, test_sequence_enable,
    output powerdown_mode_field, clock_pin_lock_gate, clock_pin_sense_gate, tx_mode,
    output gain_average_setting, channel_bw_factor, afc_enable
  );
endinterface : serial_link_if

// ===== verification/ook_link_monitor.sv
// Wire-level assertions on the serial link between the device and host ends
module ook_link_monitor
  import ook_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Link wires
  input wire logic serial_clock_pin,
  input wire logic data_dev_oe,
  input wire logic [3:0] frequency_shift_config_mantissa,
  input wire logic test_sequence_enable,
  input wire logic [1:0] powerdown_mode_field,
  input wire logic clock_pin_lock_gate,
  input wire logic clock_pin_sense_gate,
  input wire logic tx_mode,
  input wire logic [1:0] gain_average_setting,
  input wire logic [2:0] channel_bw_factor,
  input wire logic afc_enable
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic ook, lock_wait, free_run, prev_ff;
  logic [5:0] still_ff;
  assign ook = frequency_shift_config_mantissa == OOK_MANTISSA;
  assign lock_wait = powerdown_mode_field == PD_LOCK_WAIT && clock_pin_lock_gate;
  assign free_run = powerdown_mode_field == PD_NORMAL && !clock_pin_lock_gate && !clock_pin_sense_gate;
  ////////////////////////////////////////
  // Cycles since the clock pin last moved in free run, held at zero otherwise; a stuck divider shows here
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_ff <= 1'b1;
      still_ff <= 6'h00;
    end else begin
      prev_ff <= serial_clock_pin;
      still_ff <= (!free_run || serial_clock_pin != prev_ff) ? 6'h00 : still_ff + 6'h01;
    end
  end
  ////////////////////////////////////////
  a_ook_gain_avg: assert property (ook [*2] |-> gain_average_setting == GAIN_AVG_OOK)
    else $error("gain averaging not three in on-off keying");
  a_ook_bandwidth: assert property (ook [*2] |-> channel_bw_factor inside {BW_X2, BW_X4})
    else $error("bandwidth factor wrong in on-off keying");
  a_ook_no_afc: assert property (ook [*2] |-> !afc_enable)
    else $error("offset measurement on in on-off keying");
  a_sense_rx_only: assert property (tx_mode [*2] |-> !clock_pin_sense_gate)
    else $error("sense gating on in transmit");
  a_lock_pin_holds: assert property (lock_wait [*3] ##0 !serial_clock_pin |=> !serial_clock_pin || !lock_wait)
    else $error("clock pin rose after lock");
  a_lock_host_clears: assert property (lock_wait [*3] ##0 !serial_clock_pin |-> ##[0:12] powerdown_mode_field == PD_NORMAL)
    else $error("host did not leave lock wait");
  a_clock_keeps_running: assert property (still_ff < 6'h18)
    else $error("serial clock stalled");
  a_seq_releases_pin: assert property ($rose(test_sequence_enable) |-> ##[1:3] !data_dev_oe)
    else $error("data pin kept while sequence armed");
  a_sense_low_short: assert property (clock_pin_sense_gate && !lock_wait && $fell(serial_clock_pin)
    |-> ##[1:21] serial_clock_pin)
    else $error("clock pin held low under sense gating");
  cover property (lock_wait ##1 powerdown_mode_field == PD_NORMAL);
  cover property (ook && tx_mode);
  cover property (clock_pin_sense_gate && $fell(serial_clock_pin));
endmodule : ook_link_monitor

// ===== verification/tb.sv
// Bench joining the device and host ends over the serial link
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb
  import ook_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in, resetn_in, synth_locked_in, fsk_rx_bit_in;
  logic [7:0] rssi_level_in, cs_threshold_in;
  logic ook_req_in, test_seq_in, tx_mode_in, sense_gate_req_in, wait_lock_req_in;
  logic [3:0] fsk_mantissa_in;
  logic [11:0] rate_in;
  ber_mode_type ber_mode_in;
  logic tx_valid_in, tx_bit_in, tx_last_in, tx_ready_out, rx_valid_out, rx_bit_out;
  logic lock_irq_out, cfg_error_out, carrier_on_out, fsk_shift_out, carrier_sense_out;
  logic [15:0] ber_count_out;
  int mismatches, samples_checked;
  serial_link_if link();
  ook_pn9_device u_ook_pn9_device (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(1'b1),
    .link(link.device), .synth_locked_in(synth_locked_in), .rssi_level_in(rssi_level_in),
    .cs_threshold_in(cs_threshold_in), .fsk_rx_bit_in(fsk_rx_bit_in), .carrier_on_out(carrier_on_out),
    .fsk_shift_out(fsk_shift_out), .carrier_sense_out(carrier_sense_out));
  ook_pn9_host u_ook_pn9_host (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(1'b1),
    .link(link.host), .ook_req_in(ook_req_in), .fsk_mantissa_in(fsk_mantissa_in), .rate_in(rate_in),
    .test_seq_in(test_seq_in), .tx_mode_in(tx_mode_in), .sense_gate_req_in(sense_gate_req_in),
    .wait_lock_req_in(wait_lock_req_in), .ber_mode_in(ber_mode_in), .tx_valid_in(tx_valid_in),
    .tx_bit_in(tx_bit_in), .tx_last_in(tx_last_in), .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out),
    .rx_bit_out(rx_bit_out), .lock_irq_out(lock_irq_out), .cfg_error_out(cfg_error_out),
    .ber_count_out(ber_count_out));
  ook_link_monitor u_ook_link_monitor (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .serial_clock_pin(link.serial_clock_pin), .data_dev_oe(link.data_dev_oe),
    .frequency_shift_config_mantissa(link.frequency_shift_config_mantissa), .test_sequence_enable(link.test_sequence_enable),
    .powerdown_mode_field(link.powerdown_mode_field), .clock_pin_lock_gate(link.clock_pin_lock_gate),
    .clock_pin_sense_gate(link.clock_pin_sense_gate), .tx_mode(link.tx_mode),
    .gain_average_setting(link.gain_average_setting), .channel_bw_factor(link.channel_bw_factor),
    .afc_enable(link.afc_enable));
  ////////////////////////////////////////
  task automatic results;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : cyc
  task automatic wait_rx(output logic b);
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge core_clk_in);
      if (rx_valid_out === 1'b1) break;
    end
    `CHK("rx_valid", 1'b1, rx_valid_out);
    b = rx_bit_out;
  endtask : wait_rx
  task automatic count_low(output int lows);
    lows = 0;
    repeat (100) begin
      @(negedge core_clk_in);
      lows += int'(link.serial_clock_pin === 1'b0);
    end
  endtask : count_low
  ////////////////////////////////////////
  task automatic t_cfg;
    logic [11:0] rates [4] = '{12'h018, 12'h060, 12'h061, 12'h017};
    logic [2:0] bws [3] = '{BW_X4, BW_X4, BW_X2};
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_in);
      rate_in <= rates[k];
      ook_req_in <= 1'b1;
      cyc(4);
      @(negedge core_clk_in);
      `CHK("cfg_error", 1'(k == 3), cfg_error_out);
      `CHK("mantissa", (k == 3) ? 4'h3 : OOK_MANTISSA, link.frequency_shift_config_mantissa);
      if (k < 3) begin
        `CHK("gain_avg", GAIN_AVG_OOK, link.gain_average_setting);
        `CHK("bw_factor", bws[k], link.channel_bw_factor);
        `CHK("afc", 1'b0, link.afc_enable);
      end
    end
    @(posedge core_clk_in);
    ook_req_in <= 1'b0;
    rate_in <= 12'h060;
  endtask : t_cfg
  // Valid held high with a constant bit: the chips must still alternate
  task automatic t_ook_tx;
    logic prev;
    int ones;
    logic [5:0] pat;
    @(posedge core_clk_in);
    ook_req_in <= 1'b1;
    tx_mode_in <= 1'b1;
    tx_bit_in <= 1'b1;
    tx_valid_in <= 1'b1;
    repeat (4) @(negedge link.serial_clock_pin);
    prev = carrier_on_out;
    ones = 0;
    repeat (8) begin
      @(negedge link.serial_clock_pin);
      `CHK("chip_alt", ~prev, carrier_on_out);
      prev = carrier_on_out;
      ones += int'(carrier_on_out === 1'b1);
    end
    `CHK("on_chips", 4, ones);
    `CHK("fsk_shift", 1'b0, fsk_shift_out);
    // Last bit: its two chips, then the dummy tail 0,1,0,1
    @(posedge core_clk_in);
    tx_last_in <= 1'b1;
    do @(negedge core_clk_in); while (tx_ready_out !== 1'b1);
    @(posedge core_clk_in);
    tx_valid_in <= 1'b0;
    tx_last_in <= 1'b0;
    repeat (6) begin
      @(negedge link.serial_clock_pin);
      pat = {pat[4:0], carrier_on_out};
    end
    `CHK("dummy_tail", 6'h25, pat);
    @(posedge core_clk_in);
    tx_valid_in <= 1'b0;
    tx_mode_in <= 1'b0;
    ook_req_in <= 1'b0;
  endtask : t_ook_tx
  // Received data is constant zero, so the bits seen are the bare sequence
  task automatic t_pn9;
    logic r [24];
    logic b;
    int exp_n;
    @(posedge core_clk_in);
    test_seq_in <= 1'b1;
    repeat (4) wait_rx(b);
    for (int m = 1; m < 3; m++) begin
      wait_rx(b);
      @(posedge core_clk_in);
      ber_mode_in <= ber_mode_type'(m);
      exp_n = 0;
      for (int n = 0; n < 24; n++) begin
        wait_rx(r[n]);
        if (n >= 9) exp_n += int'(r[n] === 1'(m == 1));
        if (n >= 9) `CHK("pn9_recur", r[n-9] ^ r[n-5], r[n]);
      end
      cyc(3);
      `CHK("ber_count", 16'(exp_n), ber_count_out);
      `CHK("pn9_live", 1'b1, r.or());
      @(posedge core_clk_in);
      ber_mode_in <= BER_OFF;
    end
    test_seq_in <= 1'b0;
    fsk_rx_bit_in <= 1'b1;
    repeat (3) wait_rx(b);
    `CHK("rx_plain", 1'b1, b);
  endtask : t_pn9
  task automatic t_lock;
    int i;
    @(posedge core_clk_in);
    wait_lock_req_in <= 1'b1;
    @(posedge core_clk_in);
    wait_lock_req_in <= 1'b0;
    cyc(60);
    @(negedge core_clk_in);
    `CHK("pin_unlocked", 1'b1, link.serial_clock_pin);
    @(posedge core_clk_in);
    synth_locked_in <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(negedge core_clk_in);
      if (lock_irq_out === 1'b1) break;
    end
    `CHK("lock_irq", 1'b1, lock_irq_out);
    `CHK("pin_locked", 1'b0, link.serial_clock_pin);
    `CHK("pd_cleared", PD_NORMAL, link.powerdown_mode_field);
  endtask : t_lock
  task automatic t_sense;
    int lows;
    @(posedge core_clk_in);
    sense_gate_req_in <= 1'b1;
    cyc(4);
    count_low(lows);
    `CHK("gated_lows", 0, lows);
    `CHK("no_carrier", 1'b0, carrier_sense_out);
    @(posedge core_clk_in);
    rssi_level_in <= 8'hc0;
    cyc(4);
    count_low(lows);
    `CHK("clock_runs", 1'b1, 1'(lows >= 40 && lows <= 60));
    `CHK("carrier_sense", 1'b1, carrier_sense_out);
    @(posedge core_clk_in);
    tx_mode_in <= 1'b1;
    cyc(4);
    `CHK("tx_gate", 1'b0, link.clock_pin_sense_gate);
    @(posedge core_clk_in);
    sense_gate_req_in <= 1'b0;
    tx_mode_in <= 1'b0;
  endtask : t_sense
  ////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  // Whole run is near 4000 cycles; this leaves ample margin
  initial begin
    #500000;
    mismatches++;
    results();
  end
  initial begin
    resetn_in = 1'b0;
    {ook_req_in, test_seq_in, tx_mode_in, sense_gate_req_in, wait_lock_req_in} = '0;
    {tx_valid_in, tx_bit_in, tx_last_in, synth_locked_in, fsk_rx_bit_in} = '0;
    rssi_level_in = 8'h10;
    cs_threshold_in = 8'h80;
    rate_in = 12'h060;
    fsk_mantissa_in = 4'h3;
    ber_mode_in = BER_OFF;
    repeat (5) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    t_cfg();
    t_ook_tx();
    t_pn9();
    t_lock();
    t_sense();
    results();
  end
endmodule : tb
